//--- rdc_cfg_pkg.sv
`default_nettype none
package rdc_cfg_pkg;

  // ---------------------------------------------------------------
  // Register indexes (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [5:0] IDX_TLOOP     = 6'h06;
  localparam logic [5:0] IDX_AFE       = 6'h07;
  localparam logic [5:0] IDX_PHASE     = 6'h08;
  localparam logic [5:0] IDX_ENC       = 6'h09;
  localparam logic [5:0] IDX_IRQ_STAT  = 6'h10;
  localparam logic [5:0] IDX_IRQ_MASK  = 6'h11;
  localparam logic [5:0] IDX_LIVE_STAT = 6'h12;

  // ---------------------------------------------------------------
  // Reset values and writable bit masks
  // ---------------------------------------------------------------
  localparam logic [15:0] TLOOP_RESET = 16'h0004;
  localparam logic [15:0] AFE_RESET   = 16'h0005;
  localparam logic [15:0] PHASE_RESET = 16'h1400;
  localparam logic [15:0] ENC_RESET   = 16'h0002;
  localparam logic [15:0] TLOOP_WMASK = 16'h000f;
  localparam logic [15:0] AFE_WMASK   = 16'h000f;
  localparam logic [15:0] PHASE_WMASK = 16'hffff;
  localparam logic [15:0] ENC_WMASK   = 16'h01bf;
  localparam logic [1:0]  IRQ_RESET   = 2'h0;

  // ---------------------------------------------------------------
  // Field positions (least significant bit of each field)
  // ---------------------------------------------------------------
  localparam int WEIGHT_LSB   = 0;
  localparam int CLKSRC_BIT   = 3;
  localparam int SINGAIN_LSB  = 0;
  localparam int COSGAIN_LSB  = 2;
  localparam int PHVAL_LSB    = 0;
  localparam int PHSIGN_BIT   = 5;
  localparam int OFFSET_LSB   = 6;
  localparam int AMPMODE_LSB  = 10;
  localparam int AUTOEN_BIT   = 12;
  localparam int MANEN_BIT    = 13;
  localparam int UVSEL_LSB    = 14;
  localparam int SUPPLY_LSB   = 0;
  localparam int FREQ_LSB     = 3;
  localparam int POLES_LSB    = 7;
  localparam int IRQ_UV_BIT   = 0;
  localparam int IRQ_MODE_BIT = 1;

  // ---------------------------------------------------------------
  // Decode constants
  // ---------------------------------------------------------------
  localparam logic [4:0] OFFSET_TOP_DV  = 5'h14;
  localparam logic [4:0] SUPPLY_BASE_V  = 5'h0a;
  localparam logic [1:0] AMP_MODE_LOW   = 2'h1;
  localparam logic [1:0] AMP_MODE_HIGH  = 2'h2;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ              = 100;
  localparam int OR_DEGLITCH_TIME_US  = 50;
  localparam int AND_DEGLITCH_TIME_US = 1;
  localparam int OR_DEGLITCH_CYCLES   = OR_DEGLITCH_TIME_US * CLK_MHZ;
  localparam int AND_DEGLITCH_CYCLES  = AND_DEGLITCH_TIME_US * CLK_MHZ;

  typedef struct packed {
    logic [5:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } rdc_bus_req_t;

  typedef struct packed {
    logic [2:0]  integrationWeight;
    logic        exciterClockSource;
    logic [1:0]  cosineGainSel;
    logic [1:0]  sineGainSel;
    logic        manualPhaseActive;
    logic        autoPhaseActive;
    logic        phaseDelayNegative;
    logic [4:0]  phaseDelaySteps;
    logic        exciterEnable;
    logic        exciterHighAmplitude;
    logic        exciterModeFaultFlag;
    logic [4:0]  exciterOffsetDecivolt;
    logic [10:0] exciterFreqDecahertz;
    logic [2:0]  encoderPoles;
    logic [4:0]  exciterSupplyVolt;
  } rdc_cfg_out_t;

endpackage : rdc_cfg_pkg
`default_nettype wire

//--- rdc_deglitch.sv
`default_nettype none
module rdc_deglitch #(
  parameter int CYCLES = 100
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic din,
  output var  logic dout
);

  logic [15:0] count;
  wire         differs = din != dout;
  wire         expired = count == 16'(CYCLES - 1);

  // ---------------------------------------------------------------
  // Output follows input after it stood changed for CYCLES cycles
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= 16'h0000;
    end else if (!differs || expired) begin
      count <= 16'h0000;
    end else begin
      count <= count + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dout <= 1'b0;
    end else if (differs && expired) begin
      dout <= din;
    end
  end

endmodule : rdc_deglitch
`default_nettype wire

//--- rdc_cfg_regs.sv
`default_nettype none
// Summary of operation
// - Three-bit integration weight, codes select 2^8..2^15, resets to 100
// - Cosine gain bits 3-2, sine gain bits 1-0, both reset 01
// - Undervoltage fault: OR with input deglitch, AND with output deglitch, or both
// - Manual phase enable applies manual delay and overrides automatic control
// - Bit 12 enables automatic phase control, resets to one
// - Exciter mode 00/11 disables exciter, raises fault and mode-fault flag
// - Offset code maps 2.0 V down to 0.5 V in 0.1 V steps
// - Manual phase: five-bit magnitude times 0.4 us, bit 5 is sign
// - Encoder register: poles 8-7, zero bit 6, frequency 5-3, supply 2-0
// - Frequency code decodes to 10 through 20 kHz table
// - Pole-count code 00..11 selects one to four poles
module rdc_cfg_regs
#(
  parameter int OR_DEGLITCH = rdc_cfg_pkg::OR_DEGLITCH_CYCLES
) (
  input  wire logic                      clk,
  input  wire logic                      rstn,
  input  wire logic [7:0]                avsAddress,
  input  wire logic                      avsRead,
  input  wire logic                      avsWrite,
  input  wire logic [31:0]               avsWritedata,
  input  wire logic [3:0]                avsByteenable,
  output var  logic [31:0]               avsReaddata,
  output var  logic                      avsWaitrequest,
  input  wire logic                      exciterUvFirst,
  input  wire logic                      exciterUvSecond,
  output var  rdc_cfg_pkg::rdc_cfg_out_t cfgOut,
  output var  logic                      exciterUvFault,
  output var  logic                      faultOut,
  output var  logic                      irq
);

  import rdc_cfg_pkg::*;

  // ---------------------------------------------------------------
  // Bus request
  // ---------------------------------------------------------------
  rdc_bus_req_t req;
  logic         ack;
  logic [15:0]  tloopReg;
  logic [15:0]  afeReg;
  logic [15:0]  phaseReg;
  logic [15:0]  encReg;
  logic [1:0]   irqStatus;
  logic [1:0]   irqMask;
  logic [15:0]  readMux;
  logic         uvFaultPrev;
  logic         modeFaultPrev;
  rdc_cfg_out_t next_cfgOut;

  assign req.address    = avsAddress[7:2];
  assign req.read       = avsRead;
  assign req.write      = avsWrite;
  assign req.writedata  = avsWritedata;
  assign req.byteenable = avsByteenable;

  wire        busReq    = req.read | req.write;
  wire        doWrite   = req.write & ack;
  wire        loadRead  = req.read & ~ack;
  wire [15:0] laneMask  = {{8{req.byteenable[1]}}, {8{req.byteenable[0]}}};
  wire [15:0] wrData    = req.writedata[15:0];

  wire        selTloop  = req.address == IDX_TLOOP;
  wire        selAfe    = req.address == IDX_AFE;
  wire        selPhase  = req.address == IDX_PHASE;
  wire        selEnc    = req.address == IDX_ENC;
  wire        selStat   = req.address == IDX_IRQ_STAT;
  wire        selMask   = req.address == IDX_IRQ_MASK;
  wire        selLive   = req.address == IDX_LIVE_STAT;

  // Answer one cycle after the request is seen
  assign avsWaitrequest = busReq & ~ack;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack <= 1'b0;
    end else begin
      ack <= busReq & ~ack;
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wmask);
    merge = ((old & ~laneMask) | (wrData & laneMask)) & wmask;
  endfunction : merge

  wire [15:0] next_tloop = merge(tloopReg, TLOOP_WMASK);
  wire [15:0] next_afe   = merge(afeReg, AFE_WMASK);
  wire [15:0] next_phase = merge(phaseReg, PHASE_WMASK);
  wire [15:0] next_enc   = merge(encReg, ENC_WMASK);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tloopReg <= TLOOP_RESET;
      afeReg   <= AFE_RESET;
      phaseReg <= PHASE_RESET;
      encReg   <= ENC_RESET;
    end else if (doWrite) begin
      if (selTloop) begin
        tloopReg <= next_tloop;
      end
      if (selAfe) begin
        afeReg <= next_afe;
      end
      if (selPhase) begin
        phaseReg <= next_phase;
      end
      if (selEnc) begin
        encReg <= next_enc;
      end
    end
  end

  // ---------------------------------------------------------------
  // Field extraction
  // ---------------------------------------------------------------
  wire [1:0] uvSel     = phaseReg[UVSEL_LSB +: 2];
  wire       manualEn  = phaseReg[MANEN_BIT];
  wire       autoEn    = phaseReg[AUTOEN_BIT];
  wire [1:0] ampMode   = phaseReg[AMPMODE_LSB +: 2];
  wire [3:0] offsetSel = phaseReg[OFFSET_LSB +: 4];
  wire [5:0] phaseVal  = phaseReg[PHVAL_LSB +: 6];
  wire [2:0] freqSel   = encReg[FREQ_LSB +: 3];
  wire [1:0] poleSel   = encReg[POLES_LSB +: 2];
  wire [2:0] supplySel = encReg[SUPPLY_LSB +: 3];

  wire       ampValid  = (ampMode == AMP_MODE_LOW) || (ampMode == AMP_MODE_HIGH);
  wire       modeFault = !ampValid;

  // ---------------------------------------------------------------
  // Exciter undervoltage combining
  // ---------------------------------------------------------------
  logic dgFirst;
  logic dgSecond;
  logic dgBoth;

  rdc_deglitch #(.CYCLES(OR_DEGLITCH)) u_dg_first (
    .clk  (clk),
    .rstn (rstn),
    .din  (exciterUvFirst),
    .dout (dgFirst)
  );

  rdc_deglitch #(.CYCLES(OR_DEGLITCH)) u_dg_second (
    .clk  (clk),
    .rstn (rstn),
    .din  (exciterUvSecond),
    .dout (dgSecond)
  );

  rdc_deglitch #(.CYCLES(AND_DEGLITCH_CYCLES)) u_dg_both (
    .clk  (clk),
    .rstn (rstn),
    .din  (exciterUvFirst & exciterUvSecond),
    .dout (dgBoth)
  );

  wire orResult  = dgFirst | dgSecond;
  wire uvCombined = !uvSel[1] ? orResult :
                    !uvSel[0] ? dgBoth : (orResult | dgBoth);

  // ---------------------------------------------------------------
  // Decoded outputs
  // ---------------------------------------------------------------
  logic [10:0] freqDecode;

  always_comb begin
    case (freqSel)
      3'h0:    freqDecode = 11'h3e8;
      3'h1:    freqDecode = 11'h43f;
      3'h2:    freqDecode = 11'h48b;
      3'h3:    freqDecode = 11'h502;
      3'h4:    freqDecode = 11'h56d;
      3'h5:    freqDecode = 11'h61b;
      3'h6:    freqDecode = 11'h6bc;
      default: freqDecode = 11'h7d0;
    endcase
  end

  always_comb begin
    next_cfgOut                       = '0;
    next_cfgOut.integrationWeight     = tloopReg[WEIGHT_LSB +: 3];
    next_cfgOut.exciterClockSource    = tloopReg[CLKSRC_BIT];
    next_cfgOut.cosineGainSel         = afeReg[COSGAIN_LSB +: 2];
    next_cfgOut.sineGainSel           = afeReg[SINGAIN_LSB +: 2];
    next_cfgOut.manualPhaseActive     = manualEn;
    next_cfgOut.autoPhaseActive       = autoEn & ~manualEn;
    next_cfgOut.phaseDelayNegative    = manualEn & phaseVal[PHSIGN_BIT];
    next_cfgOut.phaseDelaySteps       = manualEn ? phaseVal[4:0] : 5'h00;
    next_cfgOut.exciterEnable         = ampValid;
    next_cfgOut.exciterHighAmplitude  = ampMode == AMP_MODE_HIGH;
    next_cfgOut.exciterModeFaultFlag  = modeFault;
    next_cfgOut.exciterOffsetDecivolt = OFFSET_TOP_DV - {1'b0, offsetSel};
    next_cfgOut.exciterFreqDecahertz  = freqDecode;
    next_cfgOut.encoderPoles          = {1'b0, poleSel} + 3'h1;
    next_cfgOut.exciterSupplyVolt     = SUPPLY_BASE_V + {2'h0, supplySel};
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfgOut         <= '0;
      exciterUvFault <= 1'b0;
      faultOut       <= 1'b0;
    end else begin
      cfgOut         <= next_cfgOut;
      exciterUvFault <= uvCombined;
      faultOut       <= modeFault | uvCombined;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status and mask
  // ---------------------------------------------------------------
  wire [1:0] irqEvent = {modeFault & ~modeFaultPrev, uvCombined & ~uvFaultPrev};
  wire [1:0] irqClear = (doWrite && selStat && req.byteenable[0]) ? wrData[1:0] : 2'h0;
  wire [1:0] next_irqStatus = irqEvent | (irqStatus & ~irqClear);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irqStatus     <= IRQ_RESET;
      irqMask       <= IRQ_RESET;
      uvFaultPrev   <= 1'b0;
      modeFaultPrev <= 1'b0;
    end else begin
      irqStatus     <= next_irqStatus;
      uvFaultPrev   <= uvCombined;
      modeFaultPrev <= modeFault;
      if (doWrite && selMask && req.byteenable[0]) begin
        irqMask <= wrData[1:0];
      end
    end
  end

  assign irq = |(irqStatus & irqMask);

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  always_comb begin
    if (selTloop) begin
      readMux = tloopReg;
    end else if (selAfe) begin
      readMux = afeReg;
    end else if (selPhase) begin
      readMux = phaseReg;
    end else if (selEnc) begin
      readMux = encReg;
    end else if (selStat) begin
      readMux = {14'h0000, irqStatus};
    end else if (selMask) begin
      readMux = {14'h0000, irqMask};
    end else if (selLive) begin
      readMux = {14'h0000, modeFault, uvCombined};
    end else begin
      readMux = 16'h0000;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      avsReaddata <= 32'h00000000;
    end else if (loadRead) begin
      avsReaddata <= {16'h0000, readMux};
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_bus_one_wait: assert property (@(posedge clk) disable iff (!rstn)
    (busReq && !ack) |-> avsWaitrequest ##1 (!busReq || !avsWaitrequest))
    else $error("bus answer not given one cycle after request");

  a_weight_write: assert property (@(posedge clk) disable iff (!rstn)
    (doWrite && selTloop && req.byteenable[0]) |->
      ##2 cfgOut.integrationWeight == $past(avsWritedata[2:0], 2))
    else $error("integration weight did not follow write");

  a_gain_write: assert property (@(posedge clk) disable iff (!rstn)
    (doWrite && selAfe && req.byteenable[0]) |->
      ##2 {cfgOut.cosineGainSel, cfgOut.sineGainSel} == $past(avsWritedata[3:0], 2))
    else $error("gain selectors did not follow write");

  a_uv_and_path: assert property (@(posedge clk) disable iff (!rstn)
    (uvSel == 2'h2 && $stable(uvSel) && $rose(exciterUvFault)) |-> $past(dgBoth))
    else $error("undervoltage raised without deglitched AND in AND mode");

  a_manual_priority: assert property (@(posedge clk) disable iff (!rstn)
    (manualEn && autoEn) |=> (cfgOut.manualPhaseActive && !cfgOut.autoPhaseActive))
    else $error("manual phase did not override automatic");

  a_auto_enable: assert property (@(posedge clk) disable iff (!rstn)
    (rstn && !manualEn) |=> cfgOut.autoPhaseActive == $past(phaseReg[AUTOEN_BIT]))
    else $error("automatic phase enable not applied");

  a_mode_fault: assert property (@(posedge clk) disable iff (!rstn)
    (ampMode == 2'h0 || ampMode == 2'h3) |=>
      (faultOut && cfgOut.exciterModeFaultFlag && !cfgOut.exciterEnable))
    else $error("invalid exciter mode not flagged");

  a_offset_decode: assert property (@(posedge clk) disable iff (!rstn)
    rstn |=> cfgOut.exciterOffsetDecivolt == 5'(20 - $past(offsetSel)))
    else $error("exciter offset decode wrong");

  a_phase_sign: assert property (@(posedge clk) disable iff (!rstn)
    (manualEn && phaseVal[5]) |=> cfgOut.phaseDelayNegative)
    else $error("negative manual phase not flagged");

  a_pole_decode: assert property (@(posedge clk) disable iff (!rstn)
    rstn |=> cfgOut.encoderPoles == 3'($past(poleSel)) + 3'h1)
    else $error("pole count decode wrong");

  a_reserved_zero: assert property (@(posedge clk) disable iff (!rstn)
    (loadRead && selEnc) |=> (avsReaddata[6] == 1'b0 && avsReaddata[15:9] == 7'h00))
    else $error("reserved encoder bits read nonzero");

  a_loop_reserved: assert property (@(posedge clk) disable iff (!rstn)
    (loadRead && selTloop) |=> avsReaddata[15:4] == 12'h000)
    else $error("reserved loop bits read nonzero");

  a_freq_low: assert property (@(posedge clk) disable iff (!rstn)
    (rstn && freqSel == 3'h0) |=> cfgOut.exciterFreqDecahertz == 11'h3e8)
    else $error("lowest exciter frequency decode wrong");

  a_freq_high: assert property (@(posedge clk) disable iff (!rstn)
    (rstn && freqSel == 3'h7) |=> cfgOut.exciterFreqDecahertz == 11'h7d0)
    else $error("highest exciter frequency decode wrong");

  a_uv_or_path: assert property (@(posedge clk) disable iff (!rstn)
    (!uvSel[1] && $stable(uvSel) && $rose(exciterUvFault)) |-> $past(dgFirst || dgSecond))
    else $error("undervoltage raised without deglitched input in OR mode");

  a_status_set: assert property (@(posedge clk) disable iff (!rstn)
    (irqEvent != 2'h0) |=> (irqStatus & $past(irqEvent)) == $past(irqEvent))
    else $error("interrupt event lost against clear");

  c_write_read: cover property (@(posedge clk) disable iff (!rstn)
    doWrite ##[1:4] (req.read && ack));
  c_mode_irq: cover property (@(posedge clk) disable iff (!rstn)
    $rose(modeFault) ##[1:3] irq);
  c_uv_fault: cover property (@(posedge clk) disable iff (!rstn)
    $rose(exciterUvFault));
  c_manual_override: cover property (@(posedge clk) disable iff (!rstn)
    (manualEn && autoEn) ##1 cfgOut.manualPhaseActive);
  c_and_fault: cover property (@(posedge clk) disable iff (!rstn)
    uvSel == 2'h2 && $rose(exciterUvFault));

endmodule : rdc_cfg_regs
`default_nettype wire

//--- tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rdc_cfg_pkg::*;

  // ----------------------------------------
  // Signals and design
  // ----------------------------------------
  localparam int ORD = 8;
  logic                      clk             = 1'b0;
  logic                      rstn            = 1'b0;
  logic [7:0]                avsAddress      = 8'h00;
  logic                      avsRead         = 1'b0;
  logic                      avsWrite        = 1'b0;
  logic [31:0]               avsWritedata    = 32'h0;
  logic [3:0]                avsByteenable   = 4'hf;
  logic [31:0]               avsReaddata;
  logic                      avsWaitrequest;
  logic                      exciterUvFirst  = 1'b0;
  logic                      exciterUvSecond = 1'b0;
  rdc_cfg_out_t              cfgOut;
  logic                      exciterUvFault;
  logic                      faultOut;
  logic                      irq;
  int                        failures        = 0;
  int                        nTests          = 0;
  int                        freqTab[8]      = '{1000, 1087, 1163, 1282, 1389, 1563, 1724, 2000};

  always #5 clk = ~clk;

  rdc_cfg_regs #(.OR_DEGLITCH(ORD)) dut (
    .clk(clk), .rstn(rstn), .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWritedata(avsWritedata), .avsByteenable(avsByteenable), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .exciterUvFirst(exciterUvFirst), .exciterUvSecond(exciterUvSecond),
    .cfgOut(cfgOut), .exciterUvFault(exciterUvFault), .faultOut(faultOut), .irq(irq)
  );

  // ----------------------------------------
  // Bus access and comparisons
  // ----------------------------------------
  task automatic bus_op(input logic wr, input logic [5:0] idx, input logic [15:0] d, output logic [31:0] q);
    @(posedge clk);
    avsAddress   <= {idx, 2'b00};
    avsRead      <= ~wr;
    avsWrite     <= wr;
    avsWritedata <= {16'h0000, d};
    do begin
      @(posedge clk);
    end while (avsWaitrequest !== 1'b0);
    q = avsReaddata;
    avsRead  <= 1'b0;
    avsWrite <= 1'b0;
  endtask : bus_op

  task automatic wr(input logic [5:0] idx, input logic [15:0] d);
    logic [31:0] q;
    bus_op(1'b1, idx, d, q);
  endtask : wr

  task automatic check_reg(input logic [5:0] idx, input logic [15:0] exp, input string what);
    logic [31:0] q;
    bus_op(1'b0, idx, 16'h0000, q);
    nTests++;
    if (q !== {16'h0000, exp}) begin
      failures++;
      $display("Error at %0t: %s read %h expected %h", $time, what, q, exp);
    end
  endtask : check_reg

  task automatic check_out(input logic [15:0] got, input logic [15:0] exp, input string what);
    nTests++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s is %h expected %h", $time, what, got, exp);
    end
  endtask : check_out

  // Output decode lands one edge after the storing edge; settle waits two edges
  task automatic settle;
    repeat (2) @(posedge clk);
  endtask : settle

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_n

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    settle;
    check_out(16'(cfgOut.integrationWeight), 16'h0004, "weight");
    check_out(16'({cfgOut.cosineGainSel, cfgOut.sineGainSel}), 16'h0005, "gains");
    check_out(16'(cfgOut.autoPhaseActive), 16'h0001, "auto");
    check_out(16'({cfgOut.exciterEnable, cfgOut.exciterHighAmplitude}), 16'h0002, "mode");
    check_out(16'(cfgOut.exciterOffsetDecivolt), 16'h0014, "offset");
    check_out(16'(cfgOut.exciterFreqDecahertz), 16'd1000, "freq");
    check_out(16'(cfgOut.encoderPoles), 16'h0001, "poles");
    check_out(16'(cfgOut.exciterSupplyVolt), 16'h000c, "supply");
    check_reg(IDX_AFE, 16'h0005, "gain reset");
    check_reg(IDX_PHASE, 16'h1400, "phase reset");
    check_reg(IDX_ENC, 16'h0002, "enc reset");
    check_reg(IDX_TLOOP, 16'h0004, "loop reset");
    check_reg(IDX_IRQ_MASK, 16'h0000, "mask reset");
    wr(6'h3f, 16'hffff);
    check_reg(6'h3f, 16'h0000, "unmapped");
  endtask : t_reset

  task automatic t_gain_weight;
    for (int i = 0; i < 16; i++) begin
      wr(IDX_TLOOP, 16'hfff0 | 16'(i));
      wr(IDX_AFE, 16'hfff0 | 16'(i));
      settle;
      check_out(16'({cfgOut.exciterClockSource, cfgOut.integrationWeight}), 16'(i), "loop fields");
      check_out(16'(cfgOut.cosineGainSel), 16'(i / 4), "cos gain");
      check_out(16'(cfgOut.sineGainSel), 16'(i % 4), "sin gain");
      check_reg(IDX_AFE, 16'(i), "gain reserved");
      check_reg(IDX_TLOOP, 16'(i), "loop reserved");
    end
  endtask : t_gain_weight

  task automatic t_encoder;
    for (int i = 0; i < 8; i++) begin
      wr(IDX_ENC, 16'hfe40 | 16'((i % 4) * 128 + i * 9));
      settle;
      check_out(16'(cfgOut.exciterFreqDecahertz), 16'(freqTab[i]), "freq");
      check_out(16'(cfgOut.encoderPoles), 16'(i % 4 + 1), "poles");
      check_out(16'(cfgOut.exciterSupplyVolt), 16'(10 + i), "supply");
      check_reg(IDX_ENC, 16'((i % 4) * 128 + i * 9), "enc layout");
    end
  endtask : t_encoder

  task automatic t_offset_mode;
    logic en;
    for (int i = 0; i < 16; i++) begin
      wr(IDX_PHASE, 16'h1400 | 16'(i * 64));
      settle;
      check_out(16'(cfgOut.exciterOffsetDecivolt), 16'(20 - i), "offset");
    end
    for (int i = 0; i < 4; i++) begin
      wr(IDX_PHASE, 16'h1000 | 16'(i * 1024));
      settle;
      en = (i == 1 || i == 2);
      check_out(16'({cfgOut.exciterEnable, cfgOut.exciterModeFaultFlag, faultOut}), 16'({en, !en, !en}), "mode");
      check_out(16'(cfgOut.exciterHighAmplitude), 16'(i == 2), "amplitude");
    end
    check_reg(IDX_IRQ_STAT, 16'h0002, "mode event");
    wr(IDX_IRQ_STAT, 16'h0002);
    check_reg(IDX_IRQ_STAT, 16'h0000, "event cleared");
  endtask : t_offset_mode

  task automatic t_phase;
    wr(IDX_PHASE, 16'h3425);
    settle;
    check_out(16'({cfgOut.manualPhaseActive, cfgOut.autoPhaseActive}), 16'h0002, "priority");
    check_out(16'({cfgOut.phaseDelayNegative, cfgOut.phaseDelaySteps}), 16'h0025, "delay neg");
    wr(IDX_PHASE, 16'h2405);
    settle;
    check_out(16'({cfgOut.phaseDelayNegative, cfgOut.phaseDelaySteps}), 16'h0005, "delay pos");
    wr(IDX_PHASE, 16'h1425);
    settle;
    check_out(16'({cfgOut.manualPhaseActive, cfgOut.autoPhaseActive}), 16'h0001, "auto only");
    wr(IDX_PHASE, 16'h0400);
    settle;
    check_out(16'({cfgOut.manualPhaseActive, cfgOut.autoPhaseActive}), 16'h0000, "auto off");
    avsByteenable <= 4'h1;
    wr(IDX_PHASE, 16'hffff);
    avsByteenable <= 4'hf;
    check_reg(IDX_PHASE, 16'h04ff, "low lane only");
  endtask : t_phase

  task automatic t_uv_or;
    wr(IDX_PHASE, 16'h1400);
    @(posedge clk);
    exciterUvFirst <= 1'b1;
    wait_n(3);
    exciterUvFirst <= 1'b0;
    wait_n(ORD + 6);
    check_out(16'(exciterUvFault), 16'h0000, "glitch passed");
    exciterUvFirst <= 1'b1;
    wait_n(ORD - 2);
    check_out(16'(exciterUvFault), 16'h0000, "early fault");
    wait_n(6);
    check_out(16'({exciterUvFault, faultOut, irq}), 16'h0006, "or fault masked");
    check_reg(IDX_LIVE_STAT, 16'h0001, "live uv");
    check_reg(IDX_IRQ_STAT, 16'h0001, "uv event");
    wr(IDX_IRQ_MASK, 16'h0001);
    settle;
    check_out(16'(irq), 16'h0001, "irq unmasked");
    exciterUvFirst <= 1'b0;
    wait_n(ORD + 4);
    check_out(16'({exciterUvFault, irq}), 16'h0001, "sticky");
    wr(IDX_IRQ_STAT, 16'h0001);
    settle;
    check_out(16'(irq), 16'h0000, "irq cleared");
    wr(IDX_PHASE, 16'hd400);
    exciterUvSecond <= 1'b1;
    wait_n(ORD + 4);
    check_out(16'(exciterUvFault), 16'h0001, "both mode second");
    exciterUvSecond <= 1'b0;
    wait_n(ORD + 4);
    check_out(16'(exciterUvFault), 16'h0000, "both mode idle");
  endtask : t_uv_or

  task automatic t_uv_and;
    wr(IDX_PHASE, 16'h9400);
    exciterUvFirst <= 1'b1;
    wait_n(120);
    check_out(16'(exciterUvFault), 16'h0000, "and one input");
    exciterUvSecond <= 1'b1;
    wait_n(90);
    check_out(16'(exciterUvFault), 16'h0000, "and early");
    wait_n(20);
    check_out(16'({exciterUvFault, faultOut}), 16'h0003, "and fault");
    exciterUvFirst  <= 1'b0;
    exciterUvSecond <= 1'b0;
    wait_n(120);
    check_out(16'(exciterUvFault), 16'h0000, "and idle");
    wr(IDX_IRQ_STAT, 16'h0003);
    check_reg(IDX_IRQ_STAT, 16'h0000, "all cleared");
  endtask : t_uv_and

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", nTests, failures);
    if (failures == 0 && nTests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  initial begin
    wait_n(6);
    rstn <= 1'b1;
    t_reset;
    t_gain_weight;
    t_encoder;
    t_offset_mode;
    t_phase;
    t_uv_or;
    t_uv_and;
    final_report;
  end

  initial begin
    wait_n(20000);
    failures++;
    $display("Error at %0t: run timed out", $time);
    final_report;
  end

endmodule : tb
`default_nettype wire
